//--- common/diag_pkg.sv
// What this block does
// - Diagnostic status held in one eleven-bit word.
// - Chip select high: word loads continuously.
// - Chip select low: loading stops, shifting starts.
// - Output advances on falling serial clock edges.
// - Data output floats while chip select high.
// - After eleven bits, output holds logic one.
// - Bits one to four: channel load errors.
// - Bits five to eight: commanded switch states.
// - Bit nine low above 145 C warning.
// - Bit ten low during thermal shutdown.
// - Bit eleven flags supply overvoltage above 35V.
// - Overvoltage forces switches off, with release hysteresis.
// - Undervoltage below about 5V forces switches off.
// - At 170 C all four switches turn off.
// - Switches re-enable after cooling to 160 C.
// - Enable low: sleep, switches, data output and error flag off; shutdown flag pin driven low.
// - Switch inputs ignored 30 us after enable.
// - Error flag low after 75 us persistence.
// - Shutdown flag pin driven low forces switches off.
//
// Purpose: Shared constants of the quad switch diagnostic block.
// Assumes: A 20 MHz system clock.
// Notes:   Times are kept in ns and converted to cycles here.

package diag_pkg;
    localparam int unsigned CHANNELS       = 4;
    localparam int unsigned DIAG_BITS      = 11;
    localparam int unsigned CNT_W          = 4;
    localparam int unsigned CLK_PERIOD_NS  = 50;

    // Field positions inside the diagnostic word, bit one of the word at index zero.
    localparam int unsigned LOAD_LSB       = 0;
    localparam int unsigned CMD_LSB        = 4;
    localparam int unsigned WARN_POS       = 8;
    localparam int unsigned TSD_POS        = 9;
    localparam int unsigned OV_POS         = 10;

    localparam logic [CNT_W-1:0] BITS_LAST = 4'hb;

    // Timing.
    localparam int unsigned ENABLE_DELAY_NS = 30000;
    localparam int unsigned ERROR_DELAY_NS  = 75000;
    localparam int unsigned SETUP_MIN_NS    = 500;
    localparam int unsigned ENABLE_DELAY_CYC = ENABLE_DELAY_NS / CLK_PERIOD_NS;
    localparam int unsigned ERROR_DELAY_CYC  = ERROR_DELAY_NS / CLK_PERIOD_NS;
    localparam int unsigned SETUP_MIN_CYC    =
        (SETUP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Width of the synchronised input bundle.
    localparam int unsigned SYNC_W = 18;

    // Bit positions inside the synchronised input bundle.
    localparam int unsigned SYN_FLAG     = 0;
    localparam int unsigned SYN_SCLK     = 1;
    localparam int unsigned SYN_CS_N     = 2;
    localparam int unsigned SYN_HOT      = 3;
    localparam int unsigned SYN_TRIP     = 4;
    localparam int unsigned SYN_WARN     = 5;
    localparam int unsigned SYN_UV       = 6;
    localparam int unsigned SYN_OV_HOLD  = 7;
    localparam int unsigned SYN_OV       = 8;
    localparam int unsigned SYN_LERR_LSB = 9;
    localparam int unsigned SYN_CTRL_LSB = 13;
    localparam int unsigned SYN_EN       = 17;
endpackage

//--- src/sync2.sv
// Purpose: Two flip-flop synchroniser, one stage pair per bit.
// Assumes: Inputs are asynchronous to sys_clk_in.
// Notes:   The first stage is read only by the second stage.

`timescale 1ns/1ns

module sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             sys_clk_in,  // system clock
    input  wire logic             resetn_in,   // async reset, active low
    input  wire logic [WIDTH-1:0] async_in,    // asynchronous levels
    output logic      [WIDTH-1:0] sync_out     // synchronised levels
);
    logic [WIDTH-1:0] meta_q;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                meta_q[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q[i]   <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end
endmodule

//--- src/persist_timer.sv
// Purpose: Reports a level once it has held for a set number of cycles.
// Assumes: The level is synchronous to sys_clk_in.
// Notes:   Any drop of the level restarts the count.

`timescale 1ns/1ns

module persist_timer #(
    parameter int unsigned CYCLES = 1
) (
    input  wire logic sys_clk_in,  // system clock
    input  wire logic resetn_in,   // async reset, active low
    input  wire logic level_in,    // level to be timed
    output logic      hit_out      // level held for CYCLES cycles
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LIMIT = W'(CYCLES);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    always_comb begin
        count_d = count_q;
        if (!level_in) begin
            count_d = '0;
        end else if (count_q != LIMIT) begin
            count_d = count_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign hit_out = (count_q == LIMIT);
endmodule

//--- src/quad_switch_diag.sv
// Purpose: Protection logic and serial diagnostic readout of a quad switch.
// Assumes: Analog comparators deliver plain levels; all pins are asynchronous.
// Notes:   The serial clock is sampled by sys_clk_in and its edges detected.
//          Every pin passes two flip-flops, so each pin reaches the logic two
//          cycles late; the controller's setup wait and serial clock phases of
//          at least four system cycles cover that latency.
//          Sleep clears the overvoltage and shutdown latches.

`timescale 1ns/1ns

module quad_switch_diag (
    input  wire logic       sys_clk_in,             // system clock, 20 MHz
    input  wire logic       resetn_in,              // async reset, active low
    input  wire logic       enable_in,              // device enable, low is sleep
    input  wire logic [3:0] switch_ctrl_in,         // commanded switch states
    input  wire logic [3:0] load_err_in,            // per-channel load comparator error
    input  wire logic       vcc_over_in,            // supply above 35V
    input  wire logic       vcc_over_hold_in,       // supply above 35V less 750 mV
    input  wire logic       vcc_under_in,           // supply below about 5V
    input  wire logic       temp_warn_in,           // die above 145 C
    input  wire logic       temp_trip_in,           // die at or above 170 C
    input  wire logic       temp_hot_in,            // die above 160 C
    input  wire logic       cs_n_in,                // chip select, active low
    input  wire logic       sclk_in,                // serial clock from controller
    input  wire logic       overtemp_shutdown_flag_in,     // shutdown flag pin level
    output logic            overtemp_shutdown_flag_out,    // shutdown flag pin drive value
    output logic            overtemp_shutdown_flag_oe_out, // shutdown flag pin drive enable
    output logic            sdo_out,                // serial data output value
    output logic            sdo_oe_out,             // serial data output enable
    output logic [3:0]      switch_on_out,          // switch gate drive
    output logic            error_flag_n_out,       // error flag drive value
    output logic            error_flag_n_oe_out     // error flag drive enable
);
    localparam int unsigned N = diag_pkg::CHANNELS;
    localparam int unsigned B = diag_pkg::DIAG_BITS;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [diag_pkg::SYNC_W-1:0] raw;
    logic [diag_pkg::SYNC_W-1:0] syn;

    assign raw[diag_pkg::SYN_EN]               = enable_in;
    assign raw[diag_pkg::SYN_CTRL_LSB +: N]    = switch_ctrl_in;
    assign raw[diag_pkg::SYN_LERR_LSB +: N]    = load_err_in;
    assign raw[diag_pkg::SYN_OV]               = vcc_over_in;
    assign raw[diag_pkg::SYN_OV_HOLD]          = vcc_over_hold_in;
    assign raw[diag_pkg::SYN_UV]               = vcc_under_in;
    assign raw[diag_pkg::SYN_WARN]             = temp_warn_in;
    assign raw[diag_pkg::SYN_TRIP]             = temp_trip_in;
    assign raw[diag_pkg::SYN_HOT]              = temp_hot_in;
    assign raw[diag_pkg::SYN_CS_N]             = cs_n_in;
    assign raw[diag_pkg::SYN_SCLK]             = sclk_in;
    assign raw[diag_pkg::SYN_FLAG]             = overtemp_shutdown_flag_in;

    sync2 #(
        .WIDTH (diag_pkg::SYNC_W)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .async_in   (raw),
        .sync_out   (syn)
    );

    logic         en_s;
    logic [N-1:0] ctrl_s;
    logic [N-1:0] lerr_s;
    logic         ov_s;
    logic         ov_hold_s;
    logic         uv_s;
    logic         warn_s;
    logic         trip_s;
    logic         hot_s;
    logic         cs_n_s;
    logic         sclk_s;
    logic         tflag_s;

    assign en_s      = syn[diag_pkg::SYN_EN];
    assign ctrl_s    = syn[diag_pkg::SYN_CTRL_LSB +: N];
    assign lerr_s    = syn[diag_pkg::SYN_LERR_LSB +: N];
    assign ov_s      = syn[diag_pkg::SYN_OV];
    assign ov_hold_s = syn[diag_pkg::SYN_OV_HOLD];
    assign uv_s      = syn[diag_pkg::SYN_UV];
    assign warn_s    = syn[diag_pkg::SYN_WARN];
    assign trip_s    = syn[diag_pkg::SYN_TRIP];
    assign hot_s     = syn[diag_pkg::SYN_HOT];
    assign cs_n_s    = syn[diag_pkg::SYN_CS_N];
    assign sclk_s    = syn[diag_pkg::SYN_SCLK];
    assign tflag_s   = syn[diag_pkg::SYN_FLAG];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SLEEP,
        LOAD,
        SHIFT
    } mode_t;

    typedef struct packed {
        mode_t             mode;
        logic              ov;
        logic              tsd;
        logic [B-1:0]      shreg;
        logic [diag_pkg::CNT_W-1:0] cnt;
        logic              sclk_prev;
        logic              sdo;
        logic              sdo_oe;
        logic [N-1:0]      gate;
        logic              tflag_oe;
        logic              err_oe;
    } state_t;

    state_t q;
    state_t d;

    // ------------------------------------------------------------------
    // Delays
    // ------------------------------------------------------------------
    logic armed;
    logic err_any;
    logic err_long;

    persist_timer #(
        .CYCLES (diag_pkg::ENABLE_DELAY_CYC)
    ) u_arm (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .level_in   (en_s),
        .hit_out    (armed)
    );

    persist_timer #(
        .CYCLES (diag_pkg::ERROR_DELAY_CYC)
    ) u_err (
        .sys_clk_in (sys_clk_in),
        .resetn_in  (resetn_in),
        .level_in   (err_any),
        .hit_out    (err_long)
    );

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    logic         shutdown;
    logic [B-1:0] word;

    // An external low on the flag pin reports and shuts down like a thermal trip, but sets no latch and does not drive the pin.
    // The device also sees its own pull-down through the pin, which only
    // lengthens the shutdown report by the synchroniser delay.
    assign shutdown = q.tsd | ~tflag_s;

    assign err_any = en_s & ((|lerr_s) | warn_s | q.ov | shutdown);

    always_comb begin
        word = '0;
        word[diag_pkg::LOAD_LSB +: N] = lerr_s;
        word[diag_pkg::CMD_LSB +: N]  = ctrl_s;
        word[diag_pkg::WARN_POS]      = ~warn_s;
        word[diag_pkg::TSD_POS]       = ~shutdown;
        word[diag_pkg::OV_POS]        = q.ov;
    end

    // ------------------------------------------------------------------
    // Switch permission, one stage per channel
    // ------------------------------------------------------------------
    logic         drive_ok;
    logic [N-1:0] gate_next;

    // Overvoltage, undervoltage and shutdown withdraw the permission of all four channels together.
    assign drive_ok = armed & ~q.ov & ~uv_s & ~shutdown;

    for (genvar c = 0; c < N; c++) begin : g_chan
        assign gate_next[c] = drive_ok & ctrl_s[c];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic sclk_fall;

    // The edge is found on the synchronised level, two cycles after the pin.
    assign sclk_fall = q.sclk_prev & ~sclk_s;

    always_comb begin
        d           = q;
        d.sclk_prev = sclk_s;

        // Overvoltage latch with release at the lower threshold.
        if (ov_s) begin
            d.ov = 1'b1;
        end else if (!ov_hold_s) begin
            d.ov = 1'b0;
        end

        // Thermal shutdown cycles between 170 C and 160 C.
        if (trip_s) begin
            d.tsd = 1'b1;
        end else if (!hot_s) begin
            d.tsd = 1'b0;
        end

        // Switch drive follows the per-channel permission.
        d.gate = gate_next;

        d.err_oe   = err_long;
        d.tflag_oe = q.tsd;

        case (q.mode)
            SLEEP: begin
                d.sdo_oe = 1'b0;
                d.sdo    = 1'b1;
                d.cnt    = '0;
                if (en_s) begin
                    d.mode = LOAD;
                end
            end
            LOAD: begin
                d.sdo_oe = 1'b0;
                d.cnt    = '0;
                if (!cs_n_s) begin
                    // The word of the last load cycle stays frozen, so bit one matches it.
                    d.mode   = SHIFT;
                    d.sdo_oe = 1'b1;
                    d.sdo    = q.shreg[0];
                end else begin
                    d.shreg  = word;
                end
            end
            SHIFT: begin
                d.sdo_oe = 1'b1;
                if (cs_n_s) begin
                    d.mode   = LOAD;
                    d.sdo_oe = 1'b0;
                end else if (sclk_fall) begin
                    // Ones fill from the top so a finished word reads high.
                    d.shreg = {1'b1, q.shreg[B-1:1]};
                    d.sdo   = q.shreg[1];
                    if (q.cnt != diag_pkg::BITS_LAST) begin
                        d.cnt = q.cnt + 1'b1;
                    end
                    if (q.cnt >= diag_pkg::BITS_LAST - 1'b1) begin
                        d.sdo = 1'b1;
                    end
                end
            end
            default: begin
                d.mode = SLEEP;
            end
        endcase

        // Sleep overrides everything above.
        if (!en_s) begin
            d.mode     = SLEEP;
            d.gate     = '0;
            d.sdo_oe   = 1'b0;
            d.err_oe   = 1'b0;
            d.tflag_oe = 1'b1;
            d.tsd      = 1'b0;
            d.ov       = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '{mode: SLEEP, default: '0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The controller's 500 ns setup wait covers the synchroniser latency.
    assign sdo_out                       = q.sdo;
    assign sdo_oe_out                    = q.sdo_oe;
    assign switch_on_out                 = q.gate;
    assign error_flag_n_out              = 1'b0;
    assign error_flag_n_oe_out           = q.err_oe;
    assign overtemp_shutdown_flag_out    = 1'b0;
    assign overtemp_shutdown_flag_oe_out = q.tflag_oe;
endmodule

//--- test/quad_switch_diag_asserts.sv
// Purpose: Port-level checks of the quad switch diagnostic block.
// Assumes: Latencies of a few cycles through the input synchronisers.
// Notes:   The fall and error counters are approximations that never undercount.
`timescale 1ns/1ns
module quad_switch_diag_asserts (
    input wire logic       sys_clk_in,                    // system clock
    input wire logic       resetn_in,                     // async reset, active low
    input wire logic       enable_in,                     // device enable
    input wire logic [3:0] load_err_in,                   // load errors
    input wire logic       vcc_over_in,                   // overvoltage
    input wire logic       vcc_over_hold_in,              // overvoltage hold level
    input wire logic       vcc_under_in,                  // undervoltage
    input wire logic       temp_warn_in,                  // warning temperature
    input wire logic       temp_trip_in,                  // trip temperature
    input wire logic       temp_hot_in,                   // release temperature
    input wire logic       cs_n_in,                       // chip select
    input wire logic       sclk_in,                       // serial clock
    input wire logic       overtemp_shutdown_flag_in,     // flag pin level
    input wire logic       overtemp_shutdown_flag_oe_out, // flag pin drive
    input wire logic       sdo_out,                       // data value
    input wire logic       sdo_oe_out,                    // data enable
    input wire logic [3:0] switch_on_out,                 // gate drive
    input wire logic       error_flag_n_oe_out            // error flag drive
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic [10:0] err_cnt_q;
    logic [3:0]  falls_q;
    logic [3:0]  since_q;
    logic        sclk_q;
    logic        err_src;
    logic        fall;
    assign err_src = (|load_err_in) | temp_warn_in | vcc_over_hold_in | temp_hot_in
                     | vcc_over_in | temp_trip_in | ~overtemp_shutdown_flag_in | ~enable_in;
    assign fall = sclk_q & ~sclk_in;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            err_cnt_q <= 11'h000;
            falls_q   <= 4'h0;
            since_q   <= 4'h0;
            sclk_q    <= 1'b0;
        end else begin
            err_cnt_q <= !err_src ? 11'h000 : err_cnt_q + {10'h000, err_cnt_q != 11'h7ff};
            falls_q   <= cs_n_in ? 4'h0 : falls_q + {3'h0, fall};
            since_q   <= fall ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
            sclk_q    <= sclk_in;
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    a_sdo_float_idle: assert property (cs_n_in [*5] |-> !sdo_oe_out)
        else $error("data output driven while deselected");
    a_sdo_drive_sel: assert property ((!cs_n_in && enable_in) [*8] |-> sdo_oe_out)
        else $error("data output not driven while selected");
    a_tail_ones: assert property (!cs_n_in && falls_q >= 4'hb && since_q >= 4'h6 |->
            sdo_out)
        else $error("data output not one after the last bit");
    a_sleep_off: assert property (!enable_in [*6] |-> switch_on_out == 4'h0)
        else $error("switch on during sleep");
    a_under_off: assert property (vcc_under_in [*6] |-> switch_on_out == 4'h0)
        else $error("switch on during undervoltage");
    a_over_off: assert property (vcc_over_in [*6] |-> switch_on_out == 4'h0)
        else $error("switch on during overvoltage");
    a_trip_off: assert property (temp_trip_in [*6] |->
            overtemp_shutdown_flag_oe_out && switch_on_out == 4'h0)
        else $error("switch on or flag idle at trip temperature");
    a_ext_off: assert property (!overtemp_shutdown_flag_in [*6] |-> switch_on_out == 4'h0)
        else $error("switch on while flag pin low");
    a_err_masked: assert property ($rose(error_flag_n_oe_out) |-> err_cnt_q >= 11'h5dc)
        else $error("error flag raised too early");
endmodule

bind quad_switch_diag quad_switch_diag_asserts quad_switch_diag_asserts_i (.sys_clk_in,
    .resetn_in, .enable_in, .load_err_in, .vcc_over_in, .vcc_over_hold_in, .vcc_under_in,
    .temp_warn_in, .temp_trip_in, .temp_hot_in, .cs_n_in, .sclk_in, .overtemp_shutdown_flag_in,
    .overtemp_shutdown_flag_oe_out, .sdo_out, .sdo_oe_out, .switch_on_out, .error_flag_n_oe_out);

//--- test/serial_ctrl_model.sv
// Purpose: Serial controller that frames a read of the diagnostic word.
// Assumes: The serial clock rests low between frames.
// Notes:   Twelve bits are read, the last one being the trailing level.
`timescale 1ns/1ns
module serial_ctrl_model (
    output logic      cs_n_out,    // chip select, active low
    output logic      sclk_out,    // serial clock
    input  wire logic sdo_line_in  // resolved data line
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end
    task automatic read_word(input int half_ns, output logic [11:0] word);
        cs_n_out = 1'b0;
        #600;
        for (int i = 0; i < 12; i++) begin
            sclk_out = 1'b1;
            word[i]  = sdo_line_in;
            #(half_ns);
            sclk_out = 1'b0;
            #(half_ns);
        end
        cs_n_out = 1'b1;
        #400;
    endtask
endmodule

//--- test/quad_switch_diag_test.sv
// Purpose: Self-checking bench of the quad switch diagnostic block.
// Assumes: Switches follow commands 600 cycles after reset release.
// Notes:   The data line shows a toggling pattern while not driven.
`timescale 1ns/1ns
module quad_switch_diag_test;
    logic       sys_clk_in = 1'b0;
    logic       resetn_in  = 1'b0;
    logic       enable_in  = 1'b1;
    logic [3:0] sw         = 4'h5;
    logic [3:0] le         = 4'h9;
    logic       ov         = 1'b0;
    logic       ovh        = 1'b0;
    logic       uv         = 1'b0;
    logic       warn       = 1'b0;
    logic       trip       = 1'b0;
    logic       hot        = 1'b0;
    logic       ext_n      = 1'b1;
    logic       noise      = 1'b0;
    logic       cs_n, sclk, flag_out, flag_oe, sdo, sdo_oe, err_n, err_oe;
    logic [3:0] sw_on;
    int         num_errors = 0;
    int         num_checks = 0;
    wire        flag_pin   = ext_n & ~(flag_oe & ~flag_out);
    wire        sdo_line   = sdo_oe ? sdo : noise;
    always #25 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) noise <= ~noise;
    quad_switch_diag quad_switch_diag_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .enable_in(enable_in), .switch_ctrl_in(sw), .load_err_in(le), .vcc_over_in(ov),
        .vcc_over_hold_in(ovh), .vcc_under_in(uv), .temp_warn_in(warn), .temp_trip_in(trip),
        .temp_hot_in(hot), .cs_n_in(cs_n), .sclk_in(sclk), .overtemp_shutdown_flag_in(flag_pin),
        .overtemp_shutdown_flag_out(flag_out), .overtemp_shutdown_flag_oe_out(flag_oe),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .switch_on_out(sw_on), .error_flag_n_out(err_n),
        .error_flag_n_oe_out(err_oe));
    serial_ctrl_model serial_ctrl_model_i (.cs_n_out(cs_n), .sclk_out(sclk),
        .sdo_line_in(sdo_line));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    task automatic sw_chk(input logic [3:0] e);
        cyc(10);
        chk("switch_on", {8'h00, e}, {8'h00, sw_on});
    endtask
    task automatic rd(input int half, input logic [11:0] exp, input string name);
        logic [11:0] w;
        serial_ctrl_model_i.read_word(half, w);
        chk(name, exp, w);
        cyc(1);
    endtask
    function automatic logic [11:0] word(input logic tsd, input logic ovl);
        return {1'b1, ovl, ~tsd, ~warn, sw, le};
    endfunction
    task automatic wait_err(input int n);
        for (int i = 0; i < n && err_oe !== 1'b1; i++) cyc(1);
        chk("error flag", 12'h001, {11'h000, err_oe});
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #2_000_000;
        num_errors++;
        stop_test();
    end
    initial begin
        cyc(20);
        resetn_in = 1'b1;
        cyc(300);
        sw_chk(4'h0);
        cyc(400);
        sw_chk(4'h5);
        chk("error idle", 12'h000, {11'h000, err_oe});
        chk("sdo_oe idle", 12'h000, {11'h000, sdo_oe});
        rd(200, word(1'b0, 1'b0), "word plain");
        warn = 1'b1;
        sw_chk(4'h5);
        rd(200, word(1'b0, 1'b0), "word warn");
        trip = 1'b1;
        hot = 1'b1;
        sw_chk(4'h0);
        rd(200, word(1'b1, 1'b0), "word trip");
        trip = 1'b0;
        sw_chk(4'h0);
        hot = 1'b0;
        sw_chk(4'h5);
        ov = 1'b1;
        ovh = 1'b1;
        sw_chk(4'h0);
        rd(200, word(1'b0, 1'b1), "word over");
        ov = 1'b0;
        sw_chk(4'h0);
        ovh = 1'b0;
        sw_chk(4'h5);
        uv = 1'b1;
        sw_chk(4'h0);
        uv = 1'b0;
        sw_chk(4'h5);
        ext_n = 1'b0;
        sw_chk(4'h0);
        rd(200, word(1'b1, 1'b0), "word ext");
        ext_n = 1'b1;
        sw_chk(4'h5);
        fork
            rd(400, word(1'b0, 1'b0), "word frozen");
            begin
                #1500;
                le = 4'h6;
                sw = 4'ha;
            end
        join
        rd(200, word(1'b0, 1'b0), "word reload");
        wait_err(1600);
        le = 4'h0;
        warn = 1'b0;
        cyc(20);
        chk("error clear", 12'h000, {11'h000, err_oe});
        le = 4'h1;
        cyc(1400);
        chk("error masked", 12'h000, {11'h000, err_oe});
        wait_err(200);
        enable_in = 1'b0;
        cyc(10);
        chk("sleep", 12'h001, {7'h00, sw_on, flag_oe});
        chk("drive values", 12'h000, {10'h000, err_n, flag_out});
        stop_test();
    end
endmodule
